// >>> logic/ocad_regs.svh
// Summary of operation
// - In closed-caption and normal OSD modes the low nine glyph code bits are code_bit0 to code_bit8.
// - In closed-caption and normal OSD modes code_bit9 is the top bit of the glyph code.
// - In colour-dot mode the glyph code is code_bit0 to code_bit6 and code_bit7 to code_bit9 are ignored.
// - In closed-caption mode the foreground palette comes from attr_bit11 (bit 0) to attr_bit13 (bit 2).
// - In closed-caption mode attr_bit14 set draws the character italic, clear draws it upright.
// - In closed-caption mode attr_bit15 set makes the character flash, clear keeps it steady.
// - In closed-caption mode attr_bit16 set adds an underline, clear omits it.
// - In every mode attr_bit17 set drives the secondary display output, clear keeps it inactive.
// - In closed-caption mode the background palette comes from attr_bit20 (bit 0) and attr_bit21 (bit 1).
// - In normal OSD mode the foreground palette is attr_bit11 to attr_bit14, attr_bit14 the top bit.
// - In normal OSD mode the background palette is attr_bit15, attr_bit16, attr_bit20, attr_bit21.
// - In colour-dot mode a font dot selecting palette 0 is recoloured from attr_bit13 to attr_bit16.
// - Bits 3 to 7 of the second colour byte may read back any value.
// - Entry bits unused in the current mode are still stored and read back as last written.
// - In closed-caption mode control bit 0 picks foreground palettes 0 to 7 or 8 to 15.
`ifndef OCAD_REGS_SVH
`define OCAD_REGS_SVH

// storage geometry
`define OCAD_DEPTH 64
`define OCAD_IDX_W 6
`define OCAD_ENTRY_W 24
`define OCAD_LANES 3

// register addresses: {1'b0, index, lane} for entries, plus one control register
`define OCAD_ADDR_W 9
`define OCAD_LANE_CODE 2'h0
`define OCAD_LANE_COLOR1 2'h1
`define OCAD_LANE_COLOR2 2'h2
`define OCAD_CTRL3_ADDR 9'h100
`define OCAD_CTRL3_RST 1'h0

// field positions inside a stored entry
`define OCAD_CODE_BIT6 6
`define OCAD_CODE_BIT8 8
`define OCAD_ATTR_BIT11 9
`define OCAD_ATTR_BIT12 10
`define OCAD_ATTR_BIT13 11
`define OCAD_ATTR_BIT14 12
`define OCAD_ATTR_BIT15 13
`define OCAD_ATTR_BIT16 14
`define OCAD_ATTR_BIT17 15
`define OCAD_ATTR_BIT20 16
`define OCAD_ATTR_BIT21 17
`define OCAD_CODE_BIT9 18

// mode input encodings
`define OCAD_MODE_CC 2'h0
`define OCAD_MODE_OSD 2'h1
`define OCAD_MODE_CD 2'h2

`endif

// >>> logic/ocad_pkg.sv
`include "ocad_regs.svh"
package ocad_pkg;
    typedef enum logic [1:0] {
        closed_caption_mode,
        normal_osd_mode,
        colour_dot_mode,
        reserved_mode
    } ocad_mode_t;
endpackage : ocad_pkg

// >>> logic/ocad_entry_mem.sv
`timescale 1ns/100ps
`include "ocad_regs.svh"
module ocad_entry_mem
    import ocad_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [`OCAD_IDX_W-1:0] wr_index,
    input wire logic [1:0] wr_lane,
    input wire logic [7:0] wr_data,
    input wire logic cpu_rd_en,
    input wire logic [`OCAD_IDX_W-1:0] cpu_rd_index,
    input wire logic [1:0] cpu_rd_lane,
    input wire logic cpu_rd_use_alt,
    input wire logic [7:0] cpu_rd_alt,
    output logic [7:0] cpu_rd_data,
    input wire logic disp_rd_en,
    input wire logic [`OCAD_IDX_W-1:0] disp_rd_index,
    output logic [`OCAD_ENTRY_W-1:0] disp_rd_entry
);
    typedef struct packed {
        logic [`OCAD_DEPTH-1:0][`OCAD_ENTRY_W-1:0] mem;
        logic [7:0] cpu_rd_data;
        logic [`OCAD_ENTRY_W-1:0] disp_rd_entry;
    } ocad_mem_state_t;

    ocad_mem_state_t state;
    ocad_mem_state_t next_state;
    logic [`OCAD_LANES-1:0] lane_wr;

    ////////////////////////////////////////////////////////////////////////
    // one write enable per byte lane
    genvar g;
    generate
        for (g = 0; g < `OCAD_LANES; g = g + 1) begin : g_lane
            assign lane_wr[g] = wr_en && (wr_lane == 2'(g));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // every byte is stored whole, so unused bits read back as written
    always_comb begin
        next_state = state;
        for (int k = 0; k < `OCAD_LANES; k++) begin
            if (lane_wr[k]) begin
                next_state.mem[wr_index][k*8 +: 8] = wr_data;
            end
        end
        // read data live one cycle only
        next_state.cpu_rd_data = 8'h00;
        if (cpu_rd_en) begin
            if (cpu_rd_use_alt) begin
                next_state.cpu_rd_data = cpu_rd_alt;
            end else begin
                // lane 2 bits 3..7 come back as stored, one of the allowed answers
                next_state.cpu_rd_data = state.mem[cpu_rd_index][{cpu_rd_lane, 3'h0} +: 8];
            end
        end
        // old value is seen when display reads a word being written
        if (disp_rd_en) begin
            next_state.disp_rd_entry = state.mem[disp_rd_index];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign cpu_rd_data = state.cpu_rd_data;
    assign disp_rd_entry = state.disp_rd_entry;
endmodule : ocad_entry_mem

// >>> logic/ocad_decoder.sv
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "ocad_regs.svh"
module ocad_decoder
    import ocad_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    // display mode, sampled with each fetch
    input wire logic [1:0] mode,
    // cpu register port
    input wire logic [`OCAD_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // display generator fetch
    input wire logic fetch,
    input wire logic [`OCAD_IDX_W-1:0] fetch_index,
    output logic attr_valid,
    output logic [9:0] glyph_code,
    output logic [3:0] fg_palette,
    output logic [3:0] bg_palette,
    output logic italic,
    output logic flash,
    output logic underline,
    output logic secondary_display_output,
    output logic colour_dot_active,
    // per-dot palette path
    input wire logic dot_valid,
    input wire logic [3:0] dot_palette,
    output logic pix_valid,
    output logic [3:0] pix_palette
);
    typedef struct packed {
        logic pal_range_hi;
        logic fetch_pend;
        logic [1:0] fetch_mode;
        logic [1:0] last_mode;
        logic attr_valid;
        logic [9:0] glyph_code;
        logic [3:0] fg_palette;
        logic [3:0] bg_palette;
        logic italic;
        logic flash;
        logic underline;
        logic sec_out;
        logic cd_active;
        logic [3:0] dot_override;
        logic pix_valid;
        logic [3:0] pix_palette;
    } ocad_dec_state_t;

    ocad_dec_state_t state;
    ocad_dec_state_t next_state;

    logic entry_hit;
    logic ctrl_hit;
    logic mem_wr;
    logic mem_rd;
    logic rd_use_alt;
    logic [7:0] rd_alt;
    logic [`OCAD_ENTRY_W-1:0] entry;
    ocad_mode_t cur_mode;

    ////////////////////////////////////////////////////////////////////////
    // mode code to enum; the spare code decodes as reserved
    function automatic ocad_mode_t ocad_mode_of(input logic [1:0] code);
        ocad_mode_t m;
        m = reserved_mode;
        unique case (code)
            `OCAD_MODE_CC: m = closed_caption_mode;
            `OCAD_MODE_OSD: m = normal_osd_mode;
            `OCAD_MODE_CD: m = colour_dot_mode;
            default: m = reserved_mode;
        endcase
        return m;
    endfunction : ocad_mode_of

    ////////////////////////////////////////////////////////////////////////
    // address decode: entry lanes 0..2 below the control register
    always_comb begin
        entry_hit = (reg_addr[`OCAD_ADDR_W-1] == 1'b0) && (reg_addr[1:0] != 2'h3);
        ctrl_hit = (reg_addr == `OCAD_CTRL3_ADDR);
    end

    // writes to entries go straight into storage
    assign mem_wr = reg_wr && entry_hit;
    assign mem_rd = reg_rd;

    // control and unmapped reads take the alternate byte
    always_comb begin
        rd_use_alt = !entry_hit;
        rd_alt = 8'h00;
        if (ctrl_hit) begin
            rd_alt = {5'h00, state.last_mode, state.pal_range_hi};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // character entry storage, read data registered inside
    ocad_entry_mem u_mem (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .wr_en(mem_wr),
        .wr_index(reg_addr[`OCAD_IDX_W+1:2]),
        .wr_lane(reg_addr[1:0]),
        .wr_data(reg_wdata),
        .cpu_rd_en(mem_rd),
        .cpu_rd_index(reg_addr[`OCAD_IDX_W+1:2]),
        .cpu_rd_lane(reg_addr[1:0]),
        .cpu_rd_use_alt(rd_use_alt),
        .cpu_rd_alt(rd_alt),
        .cpu_rd_data(reg_rdata),
        .disp_rd_en(fetch),
        .disp_rd_index(fetch_index),
        .disp_rd_entry(entry)
    );

    // interpretation follows the mode captured with the fetch
    assign cur_mode = ocad_mode_of(state.fetch_mode);

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        next_state = state;

        // control register: palette range select
        if (reg_wr && ctrl_hit) begin
            next_state.pal_range_hi = reg_wdata[0];
        end

        // fetch pipeline stage one: entry is being read
        next_state.fetch_pend = fetch;
        if (fetch) begin
            next_state.fetch_mode = mode;
            next_state.last_mode = mode;
        end

        // decoded attributes hold until the next fetch completes
        next_state.attr_valid = 1'b0;
        if (state.fetch_pend) begin
            next_state.attr_valid = 1'b1;
            next_state.glyph_code = 10'h000;
            next_state.fg_palette = 4'h0;
            next_state.bg_palette = 4'h0;
            next_state.italic = 1'b0;
            next_state.flash = 1'b0;
            next_state.underline = 1'b0;
            next_state.cd_active = 1'b0;
            // secondary output is honoured whatever the mode
            next_state.sec_out = entry[`OCAD_ATTR_BIT17];
            unique case (cur_mode)
                closed_caption_mode: begin
                    next_state.glyph_code[8:0] = entry[`OCAD_CODE_BIT8:0];
                    next_state.glyph_code[9] = entry[`OCAD_CODE_BIT9];
                    next_state.fg_palette = {state.pal_range_hi,
                                             entry[`OCAD_ATTR_BIT13],
                                             entry[`OCAD_ATTR_BIT12],
                                             entry[`OCAD_ATTR_BIT11]};
                    next_state.italic = entry[`OCAD_ATTR_BIT14];
                    next_state.flash = entry[`OCAD_ATTR_BIT15];
                    next_state.underline = entry[`OCAD_ATTR_BIT16];
                    next_state.bg_palette = {2'h0,
                                             entry[`OCAD_ATTR_BIT21],
                                             entry[`OCAD_ATTR_BIT20]};
                end
                normal_osd_mode: begin
                    next_state.glyph_code[8:0] = entry[`OCAD_CODE_BIT8:0];
                    next_state.glyph_code[9] = entry[`OCAD_CODE_BIT9];
                    next_state.fg_palette = {entry[`OCAD_ATTR_BIT14],
                                             entry[`OCAD_ATTR_BIT13],
                                             entry[`OCAD_ATTR_BIT12],
                                             entry[`OCAD_ATTR_BIT11]};
                    next_state.bg_palette = {entry[`OCAD_ATTR_BIT21],
                                             entry[`OCAD_ATTR_BIT20],
                                             entry[`OCAD_ATTR_BIT16],
                                             entry[`OCAD_ATTR_BIT15]};
                end
                colour_dot_mode: begin
                    // upper code bits stay stored but never reach the glyph
                    next_state.glyph_code = {3'h0, entry[`OCAD_CODE_BIT6:0]};
                    next_state.cd_active = 1'b1;
                    next_state.dot_override = {entry[`OCAD_ATTR_BIT16],
                                               entry[`OCAD_ATTR_BIT15],
                                               entry[`OCAD_ATTR_BIT14],
                                               entry[`OCAD_ATTR_BIT13]};
                end
                reserved_mode: begin
                    // spare code shows a blank character
                    next_state.glyph_code = 10'h000;
                end
            endcase
        end

        // dot path: palette 0 takes the per-character colour in colour-dot mode
        next_state.pix_valid = dot_valid;
        if (dot_valid) begin
            if (state.cd_active && (dot_palette == 4'h0)) begin
                next_state.pix_palette = state.dot_override;
            end else begin
                next_state.pix_palette = dot_palette;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
            state.pal_range_hi <= `OCAD_CTRL3_RST;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign attr_valid = state.attr_valid;
    assign glyph_code = state.glyph_code;
    assign fg_palette = state.fg_palette;
    assign bg_palette = state.bg_palette;
    assign italic = state.italic;
    assign flash = state.flash;
    assign underline = state.underline;
    assign secondary_display_output = state.sec_out;
    assign colour_dot_active = state.cd_active;
    assign pix_valid = state.pix_valid;
    assign pix_palette = state.pix_palette;
endmodule : ocad_decoder

// >>> sim/ocad_cpu_model.sv
`timescale 1ns/100ps
`include "ocad_regs.svh"
// cpu side of the register port, one strobe per call
module ocad_cpu_model (
    input wire logic sys_clk,
    output logic [`OCAD_ADDR_W-1:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // idle bus: strobes low, data parked at a value nobody asked for
    initial begin
        reg_addr = 9'h003;
        reg_wdata = 8'h5c;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // only narrow sizes are used, so block-wide attributes never diverge
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    // data is taken one cycle after the strobe, the only cycle it stands
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : ocad_cpu_model

// >>> sim/ocad_decoder_chk.sv
`timescale 1ns/100ps
module ocad_decoder_chk
    import ocad_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] mode,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic fetch,
    input wire logic attr_valid,
    input wire logic [9:0] glyph_code,
    input wire logic [3:0] fg_palette,
    input wire logic [3:0] bg_palette,
    input wire logic italic,
    input wire logic flash,
    input wire logic underline,
    input wire logic colour_dot_active,
    input wire logic dot_valid,
    input wire logic [3:0] dot_palette,
    input wire logic pix_valid,
    input wire logic [3:0] pix_palette
);
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // decode timing: exactly two cycles, never without a fetch
    a_fetch_answer: assert property (fetch |-> ##2 attr_valid)
        else $error("no decode two cycles after fetch");
    a_valid_cause: assert property (attr_valid |-> $past(fetch, 2))
        else $error("decode without fetch");
    a_fields_hold: assert property (!attr_valid |-> $stable(glyph_code)
        && $stable(fg_palette) && $stable(bg_palette)) else $error("fields moved");
    // per-mode field shapes
    a_cd_glyph: assert property (attr_valid && colour_dot_active |->
        glyph_code[9:7] == 3'h0 && fg_palette == 4'h0) else $error("colour dot fields");
    a_cd_mode: assert property (fetch && mode == colour_dot_mode |-> ##2
        colour_dot_active) else $error("colour dot not flagged");
    a_osd_plain: assert property (fetch && mode == normal_osd_mode |-> ##2
        !(italic || flash || underline)) else $error("osd styles set");
    a_cc_bg: assert property (fetch && mode == closed_caption_mode |-> ##2
        bg_palette[3:2] == 2'h0) else $error("caption background wide");
    // dot path and read port
    a_pix_next: assert property (dot_valid |=> pix_valid)
        else $error("dot lost");
    a_pix_pass: assert property (dot_valid && (dot_palette != 4'h0 ||
        !colour_dot_active) |=> pix_palette == $past(dot_palette)) else $error("dot recoloured");
    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data without read");
endmodule : ocad_decoder_chk
bind ocad_decoder ocad_decoder_chk u_chk (.sys_clk, .rst_n, .mode, .reg_rd, .reg_rdata,
    .fetch, .attr_valid, .glyph_code, .fg_palette, .bg_palette, .italic, .flash,
    .underline, .colour_dot_active, .dot_valid, .dot_palette, .pix_valid, .pix_palette);

// >>> sim/tb.sv
`timescale 1ns/100ps
module tb;
    logic sys_clk = 1'b0, rst_n = 1'b0, fetch = 1'b0, dot_valid = 1'b0, reg_wr, reg_rd;
    logic [1:0] mode = 2'h0;
    logic [5:0] fetch_index = 6'h00;
    logic [3:0] dot_palette = 4'h0, fg_palette, bg_palette, pix_palette;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [9:0] glyph_code;
    logic attr_valid, italic, flash, underline, secondary_display_output;
    logic colour_dot_active, pix_valid;
    int bad_count = 0, checks = 0;
    // 40 MHz
    always #12.5 sys_clk = ~sys_clk;
    ocad_decoder dut (.sys_clk, .rst_n, .mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .fetch, .fetch_index, .attr_valid, .glyph_code, .fg_palette,
        .bg_palette, .italic, .flash, .underline, .secondary_display_output,
        .colour_dot_active, .dot_valid, .dot_palette, .pix_valid, .pix_palette);
    ocad_cpu_model cpu (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic end_sim;
        if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic ld(input logic [5:0] i, input logic [7:0] a, b, c);
        cpu.wr({1'b0, i, 2'h0}, a);
        cpu.wr({1'b0, i, 2'h1}, b);
        cpu.wr({1'b0, i, 2'h2}, c);
    endtask : ld
    // expected fields built from the lane bytes, mode and palette range
    task automatic ft(input logic [5:0] i, input logic [1:0] md, input logic [7:0] a, b, c,
        input logic p);
        logic [9:0] g;
        logic [3:0] f, k;
        logic cc;
        cc = (md == 2'h0);
        g = md[1] ? (md[0] ? 10'h000 : {3'h0, a[6:0]}) : {c[2], b[0], a};
        f = cc ? {p, b[3:1]} : ((md == 2'h1) ? b[4:1] : 4'h0);
        k = cc ? {2'h0, c[1:0]} : ((md == 2'h1) ? {c[1:0], b[6:5]} : 4'h0);
        @(posedge sys_clk);
        fetch <= 1'b1;
        mode <= md;
        fetch_index <= i;
        @(posedge sys_clk);
        fetch <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(attr_valid, 1'b1);
        chk(glyph_code, g);
        chk(fg_palette, f);
        chk(bg_palette, k);
        chk(italic, cc & b[4]);
        chk(flash, cc & b[5]);
        chk(underline, cc & b[6]);
        chk(secondary_display_output, b[7]);
        chk(colour_dot_active, md == 2'h2);
    endtask : ft
    task automatic dt(input logic [3:0] p, input logic [3:0] e);
        @(posedge sys_clk);
        dot_valid <= 1'b1;
        dot_palette <= p;
        @(posedge sys_clk);
        dot_valid <= 1'b0;
        #1;
        chk(pix_valid, 1'b1);
        chk(pix_palette, e);
    endtask : dt
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk(glyph_code, 10'h000);
        cpu.rd(9'h100, d);
        chk(d, 8'h00);
        cpu.rd(9'h015, d);
        chk(d, 8'h00);
    endtask : t_reset
    // both palette ranges in caption mode, then every other mode
    task automatic t_modes;
        ld(6'h05, 8'ha5, 8'hb3, 8'hfd);
        ld(6'h09, 8'h5a, 8'h4c, 8'h02);
        for (int p = 0; p < 2; p++) begin
            cpu.wr(9'h100, 8'(p));
            ft(6'h05, 2'h0, 8'ha5, 8'hb3, 8'hfd, p[0]);
            ft(6'h09, 2'h0, 8'h5a, 8'h4c, 8'h02, p[0]);
        end
        for (int m = 1; m < 4; m++) begin
            ft(6'h05, m[1:0], 8'ha5, 8'hb3, 8'hfd, 1'b1);
            ft(6'h09, m[1:0], 8'h5a, 8'h4c, 8'h02, 1'b1);
        end
    endtask : t_modes
    // bits a mode ignores still read back; lane 3 is a hole
    task automatic t_store;
        cpu.rd(9'h014, d);
        chk(d, 8'ha5);
        cpu.rd(9'h015, d);
        chk(d, 8'hb3);
        cpu.rd(9'h016, d);
        chk(d & 8'h07, 8'h05);
        cpu.rd(9'h017, d);
        chk(d, 8'h00);
    endtask : t_store
    // only palette 0 takes the entry colour; 8 and others pass
    task automatic t_dots;
        ft(6'h09, 2'h1, 8'h5a, 8'h4c, 8'h02, 1'b1);
        dt(4'h0, 4'h0);
        ft(6'h05, 2'h2, 8'ha5, 8'hb3, 8'hfd, 1'b1);
        cpu.rd(9'h100, d);
        chk(d, 8'h05);
        dt(4'h0, 4'h6);
        dt(4'h8, 4'h8);
        dt(4'h3, 4'h3);
    endtask : t_dots
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset;
        t_modes;
        t_store;
        t_dots;
        end_sim;
    end
    // watchdog: the run needs fewer than a hundred cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        end_sim;
    end
endmodule : tb
